// File: logic/kli_defines.svh
// Summary of operation
// - Disabled line is plain I/O, no request
// - Enable bit n lets flag n request
// - Select zero detects low level
// - Select one detects high level
// - Both registers reset to all zeros
// - Level sets flag; software clears it
// - Eight lines share one request vector
// - Global keypad enable gates combined request
// - Detected level on an enabled line wakes core from sleep, gated like the request
`ifndef KLI_DEFINES_SVH
`define KLI_DEFINES_SVH

`define KLI_LINES            8
`define KLI_ADDR_LEVEL_SEL   8'h9c
`define KLI_ADDR_LINE_EN     8'h9d
`define KLI_ADDR_FLAGS       8'h9e
`define KLI_RST_LEVEL_SEL    8'h00
`define KLI_RST_LINE_EN      8'h00
`define KLI_RST_FLAGS        8'h00
`define KLI_RDATA_UNMAPPED   8'h00
`define KLI_SYNC_STAGES      3

`endif

// File: logic/kli_pkg.sv
package kli_pkg;

   typedef logic [7:0] kli_byte_type;
   typedef logic [7:0] kli_lines_type;

   // Which register a bus access selects
   typedef enum logic [3:0] {
      KLI_SEL_NONE      = 4'h1,
      KLI_SEL_LEVEL_SEL = 4'h2,
      KLI_SEL_LINE_EN   = 4'h4,
      KLI_SEL_FLAGS     = 4'h8
   } kli_sel_type;

endpackage

// File: logic/kli_det_if.sv
`timescale 1ns/10ps
interface kli_det_if;
   import kli_pkg::*;

   kli_lines_type level_sel;
   kli_lines_type line_level;
   kli_lines_type line_detect;

   modport ctrl (output level_sel, input line_level, input line_detect);
   modport det  (input level_sel, output line_level, output line_detect);
endinterface

// File: logic/kli_line_sync.sv
`timescale 1ns/10ps
`include "kli_defines.svh"
module kli_line_sync
   import kli_pkg::*;
#(
   parameter int LINES = `KLI_LINES
) (
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   input  wire logic [LINES-1:0] port1_pin,
   kli_det_if.det                det
);

   logic [LINES-1:0] s1_ff;
   logic [LINES-1:0] s2_ff;
   logic [LINES-1:0] s3_ff;
   logic [LINES-1:0] stable_ff;
   logic [LINES-1:0] nxt_stable;

   genvar g;
   generate
      for (g = 0; g < LINES; g = g + 1) begin : g_line
         // A change is accepted only when the last two stages agree
         assign nxt_stable[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : stable_ff[g];
         // Select zero: low level detected; select one: high level detected
         assign det.line_detect[g] = det.level_sel[g] ? stable_ff[g] : ~stable_ff[g];
      end
   endgenerate

   assign det.line_level = stable_ff;

   // Idle keypad lines are pulled up, so reset to ones avoids a false low detect
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s1_ff     <= '1;
         s2_ff     <= '1;
         s3_ff     <= '1;
         stable_ff <= '1;
      end else begin
         s1_ff     <= port1_pin;
         s2_ff     <= s1_ff;
         s3_ff     <= s2_ff;
         stable_ff <= nxt_stable;
      end
   end

endmodule

// File: logic/kli_top.sv
`timescale 1ns/10ps
`include "kli_defines.svh"
module kli_top
   import kli_pkg::*;
#(
   parameter int LINES = `KLI_LINES
) (
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   input  wire logic [7:0]       sfr_addr,
   input  wire logic             sfr_wr,
   input  wire logic             sfr_rd,
   input  wire logic [7:0]       sfr_wdata,
   output logic      [7:0]       sfr_rdata,
   input  wire logic [LINES-1:0] port1_pin,
   input  wire logic             keypad_global_irq_enable,
   output logic                  keypad_irq,
   output logic                  keypad_wake,
   output logic      [LINES-1:0] line_alt_func,
   output logic      [LINES-1:0] line_level
);

   // Shared decode used by both the write path and the read path
   function automatic kli_sel_type kli_decode(input logic [7:0] addr);
      kli_sel_type sel;
      case (addr)
         `KLI_ADDR_LEVEL_SEL: begin
            sel = KLI_SEL_LEVEL_SEL;
         end
         `KLI_ADDR_LINE_EN: begin
            sel = KLI_SEL_LINE_EN;
         end
         `KLI_ADDR_FLAGS: begin
            sel = KLI_SEL_FLAGS;
         end
         default: begin
            sel = KLI_SEL_NONE;
         end
      endcase
      return sel;
   endfunction

   // Registers narrower than a byte read back with zeros above
   function automatic kli_byte_type kli_pad_byte(input logic [LINES-1:0] bits);
      return kli_byte_type'(bits);
   endfunction

   // Register state
   logic [LINES-1:0] line_level_select_ff;
   logic [LINES-1:0] line_irq_enable_ff;
   logic [LINES-1:0] line_detect_flag_ff;
   logic [7:0]       rdata_ff;
   logic             irq_ff;
   logic             wake_ff;
   logic [LINES-1:0] alt_func_ff;
   logic [LINES-1:0] level_ff;

   // Next values
   logic [LINES-1:0] nxt_line_level_select;
   logic [LINES-1:0] nxt_line_irq_enable;
   logic [LINES-1:0] nxt_line_detect_flag;
   logic [7:0]       nxt_rdata;
   logic             nxt_irq;
   logic             nxt_wake;

   // Decode and selection wires
   kli_sel_type      bus_sel;
   logic             wr_level_sel;
   logic             wr_line_en;
   logic             wr_flags;
   logic [LINES-1:0] flag_clear;
   logic [LINES-1:0] flag_set;
   logic [LINES-1:0] flags_masked;
   logic             any_flag_masked;
   logic [7:0]       rd_mux;
   logic [7:0]       level_sel_byte;
   logic [7:0]       line_en_byte;
   logic [7:0]       flags_byte;

   kli_det_if det_bus ();

   kli_line_sync #(
      .LINES     (LINES)
   ) u_line_sync (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .port1_pin (port1_pin),
      .det       (det_bus.det)
   );

   assign det_bus.level_sel = line_level_select_ff;

   // Register bus decode
   assign bus_sel      = kli_decode(sfr_addr);
   assign wr_level_sel = sfr_wr && (bus_sel == KLI_SEL_LEVEL_SEL);
   assign wr_line_en   = sfr_wr && (bus_sel == KLI_SEL_LINE_EN);
   assign wr_flags     = sfr_wr && (bus_sel == KLI_SEL_FLAGS);

   assign nxt_line_level_select = wr_level_sel ? sfr_wdata[LINES-1:0] : line_level_select_ff;
   assign nxt_line_irq_enable   = wr_line_en ? sfr_wdata[LINES-1:0] : line_irq_enable_ff;

   assign flag_set = det_bus.line_detect;

   // Writing zero to a flag bit clears it; writing one leaves it alone.
   // A detection in the same cycle as the clear keeps the flag set.
   genvar g;
   generate
      for (g = 0; g < LINES; g = g + 1) begin : g_flag
         assign flag_clear[g]           = wr_flags && !sfr_wdata[g];
         assign nxt_line_detect_flag[g] = (line_detect_flag_ff[g] && !flag_clear[g]) || flag_set[g];
         // Flags still record levels on disabled lines, but never request
         assign flags_masked[g]         = line_detect_flag_ff[g] && line_irq_enable_ff[g];
      end
   endgenerate

   assign any_flag_masked = |flags_masked;
   assign nxt_irq         = any_flag_masked && keypad_global_irq_enable;

   // Wake follows the same gating so a masked key cannot rouse a sleeping core
   assign nxt_wake = nxt_irq;

   // Read path
   assign level_sel_byte = kli_pad_byte(line_level_select_ff);
   assign line_en_byte   = kli_pad_byte(line_irq_enable_ff);
   assign flags_byte     = kli_pad_byte(line_detect_flag_ff);

   always_comb begin
      rd_mux = `KLI_RDATA_UNMAPPED;
      unique case (bus_sel)
         KLI_SEL_LEVEL_SEL: begin
            rd_mux = level_sel_byte;
         end
         KLI_SEL_LINE_EN: begin
            rd_mux = line_en_byte;
         end
         KLI_SEL_FLAGS: begin
            rd_mux = flags_byte;
         end
         // Unmapped addresses read zero, never stale data
         KLI_SEL_NONE: begin
            rd_mux = `KLI_RDATA_UNMAPPED;
         end
      endcase
   end

   // Read data holds between reads so the core may sample late
   assign nxt_rdata = sfr_rd ? rd_mux : rdata_ff;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         line_level_select_ff <= LINES'(`KLI_RST_LEVEL_SEL);
      end else begin
         line_level_select_ff <= nxt_line_level_select;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         line_irq_enable_ff <= LINES'(`KLI_RST_LINE_EN);
      end else begin
         line_irq_enable_ff <= nxt_line_irq_enable;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         line_detect_flag_ff <= LINES'(`KLI_RST_FLAGS);
      end else begin
         line_detect_flag_ff <= nxt_line_detect_flag;
      end
   end

   // Request is a registered level so the core never sees decode glitches
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= nxt_irq;
      end
   end

   // Wake has its own flop so it can be moved to an always-on area alone
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wake_ff <= 1'b0;
      end else begin
         wake_ff <= nxt_wake;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdata_ff <= `KLI_RDATA_UNMAPPED;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // Port mux hint and level mirror are registered to keep outputs glitch free
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         alt_func_ff <= '0;
      end else begin
         alt_func_ff <= nxt_line_irq_enable;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         level_ff <= '1;
      end else begin
         level_ff <= det_bus.line_level;
      end
   end

   assign sfr_rdata     = rdata_ff;
   assign keypad_irq    = irq_ff;
   assign keypad_wake   = wake_ff;
   assign line_alt_func = alt_func_ff;
   assign line_level    = level_ff;

endmodule

// File: sim/kli_keypad_model.sv
`timescale 1ns/10ps
module kli_keypad_model (
   input wire logic [7:0] key_down,
   input wire logic [7:0] press_high,
   output logic     [7:0] port1_pin
);
   // A released key rests at the pull opposite its pressed level, never at a stale value
   assign port1_pin = ~(key_down ^ press_high);
endmodule

// File: sim/kli_top_sva.sv
`timescale 1ns/10ps
module kli_top_sva #(parameter int LINES = 8) (
   input wire logic             sys_clk,
   input wire logic             sys_rst,
   input wire logic [7:0]       sfr_addr,
   input wire logic             sfr_wr,
   input wire logic             sfr_rd,
   input wire logic [7:0]       sfr_wdata,
   input wire logic [7:0]       sfr_rdata,
   input wire logic [LINES-1:0] port1_pin,
   input wire logic             keypad_global_irq_enable,
   input wire logic             keypad_irq,
   input wire logic             keypad_wake,
   input wire logic [LINES-1:0] line_alt_func,
   input wire logic [LINES-1:0] line_level
);
   logic [LINES-1:0] sel_ff;
   logic             hit;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Level select is not visible at the ports, so it is shadowed here
   always_ff @(posedge sys_clk)
      if (sys_rst)
         sel_ff <= '0;
      else if (sfr_wr && sfr_addr == 8'h9c)
         sel_ff <= sfr_wdata[LINES-1:0];
   assign hit = keypad_global_irq_enable && |(line_alt_func & ~(line_level ^ sel_ff));
   chk_level_irq: assert property (hit ##1 hit |=> keypad_irq) else $error("no irq");
   chk_flag_holds: assert property (!sfr_wr ##1 (!sfr_wr && keypad_irq && keypad_global_irq_enable) |=> keypad_irq)
      else $error("irq lost");
   chk_reset_clear: assert property ($fell(sys_rst) |-> !line_alt_func && !keypad_irq && !sfr_rdata) else $error("rst");
   chk_global_gate: assert property (!keypad_global_irq_enable |=> !keypad_irq) else $error("global");
   chk_wake_irq: assert property (keypad_wake == keypad_irq) else $error("wake");
   chk_plain_io: assert property (line_alt_func == '0 |=> !keypad_irq) else $error("plain io");
   chk_enable_wr: assert property (sfr_wr && sfr_addr == 8'h9d |=> line_alt_func == $past(sfr_wdata))
      else $error("enable");
   chk_select_rd: assert property (sfr_rd && !sfr_wr && sfr_addr == 8'h9c |=> sfr_rdata == $past(sel_ff))
      else $error("select");
   cover property (hit ##1 hit ##1 keypad_irq);
   cover property (sfr_wr && sfr_addr == 8'h9e);
   cover property ($fell(keypad_irq));
endmodule
bind kli_top kli_top_sva #(.LINES(LINES)) u_sva (.sys_clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
   .sfr_rdata, .port1_pin, .keypad_global_irq_enable, .keypad_irq, .keypad_wake, .line_alt_func, .line_level);

// File: sim/test_keypad_level_interrupt.sv
`timescale 1ns/10ps
module test_keypad_level_interrupt;
   logic       sys_clk, sys_rst, sfr_wr, sfr_rd, glob_en, keypad_irq, keypad_wake;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, port1_pin, line_alt_func, line_level;
   logic [7:0] key_down, press_high, bit_n, en_exp;
   int         n_mismatch, check_count;
   kli_top u_dut (.sys_clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .port1_pin,
      .keypad_global_irq_enable(glob_en), .keypad_irq, .keypad_wake, .line_alt_func, .line_level);
   kli_keypad_model u_keys (.key_down, .press_high, .port1_pin);
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge sys_clk);
      sfr_rd <= 1'b0;
      @(negedge sys_clk);
      chk(sfr_rdata, e);
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge sys_clk);
      sfr_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Sampled mid-cycle so the launching edge has settled
   task automatic look(input logic e);
      @(negedge sys_clk);
      chk({6'h00, keypad_wake, keypad_irq}, {6'h00, e, e});
      chk(line_alt_func, en_exp);
      chk(line_level, port1_pin);
      @(posedge sys_clk);
   endtask
   initial begin
      {sys_rst, sfr_wr, sfr_rd, glob_en} = 4'b1001;
      {sfr_addr, sfr_wdata, key_down, press_high, en_exp} = '0;
      {n_mismatch, check_count} = '0;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      rd(8'h9c, 8'h00);
      rd(8'h9d, 8'h00);
      // Odd lines detect high, even lines low, so both pull directions get used
      for (int n = 0; n < 8; n++) begin
         bit_n = 8'h01 << n;
         press_high[n] <= n[0];
         repeat (6) @(posedge sys_clk);
         wr(8'h9c, press_high);
         // Moving the pull level can latch a stale flag
         wr(8'h9e, 8'h00);
         rd(8'h9c, press_high);
         key_down <= bit_n;
         repeat (8) @(posedge sys_clk);
         look(1'b0);
         rd(8'h9e, bit_n);
         // A clear while the key is still held loses to the level
         wr(8'h9e, 8'h00);
         rd(8'h9e, bit_n);
         // Unmapped address reads zero, not the last value read
         rd(8'h9f, 8'h00);
         wr(8'h9d, bit_n);
         en_exp = bit_n;
         look(1'b1);
         glob_en <= 1'b0;
         repeat (2) @(posedge sys_clk);
         look(1'b0);
         glob_en <= 1'b1;
         key_down <= 8'h00;
         repeat (8) @(posedge sys_clk);
         look(1'b1);
         wr(8'h9e, ~bit_n);
         look(1'b0);
         wr(8'h9d, 8'h00);
         en_exp = 8'h00;
      end
      stop_test();
   end
   // The sequence needs about 410 cycles; 5000 leaves ample margin
   initial begin
      #20000;
      n_mismatch++;
      stop_test();
   end
endmodule
